// >>> hw/stpcfg_cfg.svh
// Purpose: Constants for the stepper slave switch configuration block
// Assumes: 50 MHz system clock
// Notes:   Switch bit positions count from zero
`ifndef STPCFG_CFG_SVH
`define STPCFG_CFG_SVH

// Address switch
`define STPCFG_ADDR_W          4
`define STPCFG_ADDR_MASTER     4'h0
`define STPCFG_ADDR_RESET      4'h0

// Rate switch bits (bit 0 = position 1)
`define STPCFG_RATE_W          4
`define STPCFG_RATE_LO_POS     0
`define STPCFG_RATE_HI_POS     1
`define STPCFG_RATE_10M_CODE   2'h2
`define STPCFG_RATE_20M_CODE   2'h3

// Step code field
`define STPCFG_STEP_W          3
`define STPCFG_STEP_FACTORY    3'h3

// Hold switching time
`define STPCFG_HOLD_MS         150
`define STPCFG_HOLD_FAST_MS    50
`define STPCFG_CLK_HZ          50000000
`define STPCFG_HOLD_CYCLES     ((`STPCFG_HOLD_MS * (`STPCFG_CLK_HZ / 1000)))
`define STPCFG_HOLD_FAST_CYCLES ((`STPCFG_HOLD_FAST_MS * (`STPCFG_CLK_HZ / 1000)))

`endif

// >>> hw/stpcfg_hold_timer.sv
// Purpose: Drive/hold current switching timer, retriggered by drive pulses
// Assumes: Pulse input synchronous to clk_sys
// Notes:   Interval counts set by parameters so simulation can shorten them
`timescale 1ns/10ps
`default_nettype none
`include "stpcfg_cfg.svh"

module stpcfg_hold_timer #(
    parameter int unsigned SLOW_CYCLES = `STPCFG_HOLD_CYCLES,
    parameter int unsigned FAST_CYCLES = `STPCFG_HOLD_FAST_CYCLES
) (
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               reset,
    // Control
    input  wire logic               drive_pulse,
    input  wire logic               hold_fast,
    // Status
    output logic                    drive_level,
    output logic [31:0]             idle_count
);

    // Elaboration check; a zero interval could never be counted down
    if (SLOW_CYCLES < 1 || FAST_CYCLES < 1) begin
        $error("hold timer counts must be at least one");
    end

    stpcfg_pkg::stpcfg_cur_t state_ff;
    stpcfg_pkg::stpcfg_cur_t nxt_state;
    logic [31:0]             cnt_ff;
    logic [31:0]             nxt_cnt;
    logic [31:0]             limit;

    // Any pulse restarts the interval; expiry returns to hold level
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        limit     = hold_fast ? FAST_CYCLES : SLOW_CYCLES;
        case (state_ff)
            stpcfg_pkg::STPCFG_HOLD: begin
                if (drive_pulse) begin
                    nxt_state = stpcfg_pkg::STPCFG_DRIVE;
                    nxt_cnt   = 32'h0;
                end
            end
            stpcfg_pkg::STPCFG_DRIVE: begin
                if (drive_pulse) begin
                    nxt_cnt = 32'h0;
                end else if (cnt_ff + 32'h1 >= limit) begin
                    nxt_state = stpcfg_pkg::STPCFG_HOLD;
                    nxt_cnt   = 32'h0;
                end else begin
                    nxt_cnt = cnt_ff + 32'h1;
                end
            end
            default: begin
                nxt_state = stpcfg_pkg::STPCFG_HOLD;
                nxt_cnt   = 32'h0;
            end
        endcase
    end

    // State registers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_ff <= stpcfg_pkg::STPCFG_HOLD;
            cnt_ff   <= 32'h0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
        end
    end

    assign drive_level = (state_ff == stpcfg_pkg::STPCFG_DRIVE);
    assign idle_count  = cnt_ff;

endmodule

`default_nettype wire

// >>> hw/stpcfg_pkg.sv
// Purpose: Types for the stepper slave switch configuration block
// Assumes: Constants come from stpcfg_cfg.svh
// Notes:   No code values on enums
package stpcfg_pkg;

    // Network rate selection
    typedef enum logic [1:0] {
        STPCFG_RATE_NONE,
        STPCFG_RATE_10M,
        STPCFG_RATE_20M
    } stpcfg_rate_t;

    // Step division selection
    typedef enum logic [2:0] {
        STPCFG_DIV_1,
        STPCFG_DIV_2,
        STPCFG_DIV_4,
        STPCFG_DIV_10,
        STPCFG_DIV_20,
        STPCFG_DIV_40
    } stpcfg_div_t;

    // Current level state
    typedef enum logic {
        STPCFG_HOLD,
        STPCFG_DRIVE
    } stpcfg_cur_t;

    // Captured configuration
    typedef struct packed {
        logic [3:0]   addr;
        stpcfg_rate_t rate;
        stpcfg_div_t  div;
        logic         hold_fast;
        logic         net_enable;
    } stpcfg_conf_t;

endpackage

// >>> hw/stpcfg_top.sv
// Purpose: Switch capture, decode and current control of a stepper slave unit
// Assumes: Switch inputs are steady during power-up; reset is the power-on reset
// Notes:   Switches are read once after reset release, never again
//          A prohibited address or rate keeps the unit off the network
//          Every step code pattern maps to a division, so it has no error flag
`timescale 1ns/10ps
`default_nettype none
`include "stpcfg_cfg.svh"

// The reset input is treated as the power-on reset: capture happens on the
// first clock after it falls, so every later reset takes a fresh reading.

// Behaviour
// - Slave address from 4-bit switch, 1 to 15
// - Address zero belongs to master only
// - Switches sampled only at power-up
// - Rate bits 10 give 10M, 11 20M
// - Pulses select drive current, idle returns hold
// - Default reversion interval is 150 ms
// - Step code decodes to six divisions
// - High and mid off give 1/40
// - Factory step setting gives 1/20
module stpcfg_top #(
    parameter int unsigned HOLD_CYCLES      = `STPCFG_HOLD_CYCLES,
    parameter int unsigned HOLD_FAST_CYCLES = `STPCFG_HOLD_FAST_CYCLES
) (
    // Clock and reset
    input  wire logic                         clk_sys,
    input  wire logic                         reset,
    // Network switches
    input  wire logic [`STPCFG_ADDR_W-1:0]    address_switch,
    input  wire logic [`STPCFG_RATE_W-1:0]    rate_switch,
    // Driver switches
    input  wire logic                         hold_time_select,
    input  wire logic                         step_code_high,
    input  wire logic                         step_code_mid,
    input  wire logic                         step_code_low,
    input  wire logic                         pulse_input_type_select,
    // Drive pulse from the pulse generator
    input  wire logic                         drive_pulse,
    // Network configuration
    output logic [`STPCFG_ADDR_W-1:0]         slave_address,
    output stpcfg_pkg::stpcfg_rate_t          net_rate,
    output logic                              net_enable,
    output logic                              config_valid,
    output logic                              addr_error,
    output logic                              rate_error,
    // Driver configuration
    output stpcfg_pkg::stpcfg_div_t           step_division,
    output logic                              pulse_type_error,
    output logic                              drive_current
);

    // Elaboration checks; the fast interval may not outlast the default one
    if (HOLD_CYCLES < 1 || HOLD_FAST_CYCLES < 1 || HOLD_FAST_CYCLES > HOLD_CYCLES) begin
        $error("hold interval counts out of range");
    end

    // The configuration word keeps a 4-bit address; a wider switch would be cut
    if (`STPCFG_ADDR_W != 4) begin
        $error("address switch width must match the configuration word");
    end

    // The upper pair of rate positions must exist to be checked for prohibited use
    if (`STPCFG_RATE_W != 4) begin
        $error("rate switch must have four positions");
    end

    // Decode helpers. They act only at the single capture edge, so they cost one
    // rank of logic in front of the configuration flops and nothing afterwards.
    // Prohibited patterns decode to a safe value rather than a guess, so a
    // miswired switch shows up as an error flag instead of a wrong setting.

    // Address check; master address is never a slave address
    // Any of 1 to 15 is a usable slave address; zero alone is refused
    function automatic logic addr_ok(input logic [`STPCFG_ADDR_W-1:0] a);
        addr_ok = (a != `STPCFG_ADDR_MASTER);
    endfunction

    // Rate decode; upper bits set count as prohibited
    function automatic stpcfg_pkg::stpcfg_rate_t rate_dec(input logic [`STPCFG_RATE_W-1:0] r);
        logic [1:0] lo;
        lo = r[`STPCFG_RATE_HI_POS:`STPCFG_RATE_LO_POS];
        if (r[`STPCFG_RATE_W-1:2] != 2'h0) begin
            // Any upper position on spoils the setting, whatever the low pair says
            rate_dec = stpcfg_pkg::STPCFG_RATE_NONE;
        end else if (lo == `STPCFG_RATE_10M_CODE) begin
            rate_dec = stpcfg_pkg::STPCFG_RATE_10M;
        end else if (lo == `STPCFG_RATE_20M_CODE) begin
            rate_dec = stpcfg_pkg::STPCFG_RATE_20M;
        end else begin
            // Low pair 00 or 01 has no rate assigned
            rate_dec = stpcfg_pkg::STPCFG_RATE_NONE;
        end
    endfunction

    // Rate usable on the network
    function automatic logic rate_ok(input stpcfg_pkg::stpcfg_rate_t r);
        rate_ok = (r != stpcfg_pkg::STPCFG_RATE_NONE);
    endfunction

    // Whole network setting usable; both checks must pass before the unit speaks
    function automatic logic net_ok(input logic [`STPCFG_ADDR_W-1:0] a,
                                    input stpcfg_pkg::stpcfg_rate_t r);
        net_ok = addr_ok(a) && rate_ok(r);
    endfunction

    // Step division decode
    function automatic stpcfg_pkg::stpcfg_div_t div_dec(input logic [2:0] s);
        case (s)
            3'h7:    div_dec = stpcfg_pkg::STPCFG_DIV_1;
            3'h6:    div_dec = stpcfg_pkg::STPCFG_DIV_2;
            3'h5:    div_dec = stpcfg_pkg::STPCFG_DIV_4;
            3'h4:    div_dec = stpcfg_pkg::STPCFG_DIV_10;
            3'h3:    div_dec = stpcfg_pkg::STPCFG_DIV_20;
            3'h2:    div_dec = stpcfg_pkg::STPCFG_DIV_40;
            // High and mid off: finest division, low bit ignored
            default: div_dec = stpcfg_pkg::STPCFG_DIV_40;
        endcase
    endfunction

    // Captured configuration and error flags, with their next values
    stpcfg_pkg::stpcfg_conf_t conf_ff;
    stpcfg_pkg::stpcfg_conf_t nxt_conf;
    logic                     captured_ff;
    logic                     nxt_captured;
    logic                     addr_err_ff;
    logic                     nxt_addr_err;
    logic                     rate_err_ff;
    logic                     nxt_rate_err;
    logic                     ptype_err_ff;
    logic                     nxt_ptype_err;
    // Live switch readings, used only at the capture edge
    logic [2:0]               step_code;
    stpcfg_pkg::stpcfg_rate_t rate_now;

    // Step code as one field, high bit first
    assign step_code = {step_code_high, step_code_mid, step_code_low};
    assign rate_now  = rate_dec(rate_switch);

    // One capture at the first edge after reset release; later switch moves are ignored.
    // captured_ff closes the gate for good, so a switch knocked while powered
    // cannot move the address or rate under a running network.
    always_comb begin
        nxt_conf      = conf_ff;
        nxt_captured  = captured_ff;
        nxt_addr_err  = addr_err_ff;
        nxt_rate_err  = rate_err_ff;
        nxt_ptype_err = ptype_err_ff;
        if (!captured_ff) begin
            nxt_captured         = 1'b1;
            nxt_conf.addr        = address_switch;
            nxt_conf.rate        = rate_now;
            nxt_conf.div         = div_dec(step_code);
            nxt_conf.hold_fast   = hold_time_select;
            nxt_addr_err         = !addr_ok(address_switch);
            nxt_rate_err         = !rate_ok(rate_now);
            // Pulse input type is only flagged; this block serves one pulse form
            nxt_ptype_err        = pulse_input_type_select;
            // Stay silent rather than join the network with a guessed setting
            nxt_conf.net_enable  = net_ok(address_switch, rate_now);
        end
    end

    // Configuration registers; reset values keep the unit offline
    // Step division resets to the factory setting so early readers see a sane value
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            conf_ff.addr       <= `STPCFG_ADDR_RESET;
            conf_ff.rate       <= stpcfg_pkg::STPCFG_RATE_NONE;
            conf_ff.div        <= stpcfg_pkg::STPCFG_DIV_20;
            conf_ff.hold_fast  <= 1'b0;
            conf_ff.net_enable <= 1'b0;
            captured_ff        <= 1'b0;
            addr_err_ff        <= 1'b0;
            rate_err_ff        <= 1'b0;
            ptype_err_ff       <= 1'b0;
        end else begin
            // Capture and flags move together, so outputs never mix two readings
            conf_ff      <= nxt_conf;
            captured_ff  <= nxt_captured;
            addr_err_ff  <= nxt_addr_err;
            rate_err_ff  <= nxt_rate_err;
            ptype_err_ff <= nxt_ptype_err;
        end
    end

    // Current switching timer; uses latched hold select only.
    // Pulses are gated until capture, so a pulse that overlaps power-on reset
    // cannot start drive current before the interval choice is known.
    stpcfg_hold_timer #(
        .SLOW_CYCLES (HOLD_CYCLES),
        .FAST_CYCLES (HOLD_FAST_CYCLES)
    ) u_hold (
        .clk_sys     (clk_sys),
        .reset       (reset),
        .drive_pulse (drive_pulse && captured_ff),
        .hold_fast   (conf_ff.hold_fast),
        .drive_level (drive_current),
        .idle_count  ()
    );

    // Outputs straight from configuration flops
    // No logic sits between flop and port, so these never glitch
    assign slave_address    = conf_ff.addr;
    assign net_rate         = conf_ff.rate;
    assign net_enable       = conf_ff.net_enable;
    assign config_valid     = captured_ff;
    assign addr_error       = addr_err_ff;
    assign rate_error       = rate_err_ff;
    assign step_division    = conf_ff.div;
    assign pulse_type_error = ptype_err_ff;

endmodule

`default_nettype wire

// >>> tb/stpcfg_master_model.sv
// Purpose: Network master seen from one slave, reports a usable link
// Assumes: Master owns address 0 and runs at master_rate
// Notes:   Link flag is registered, one cycle behind the slave outputs
`timescale 1ns/10ps
`default_nettype none

module stpcfg_master_model (
    // Clock and reset
    input  wire logic                      clk_sys,
    input  wire logic                      reset,
    // Master setting
    input  wire stpcfg_pkg::stpcfg_rate_t  master_rate,
    // Slave configuration
    input  wire logic [3:0]                slave_address,
    input  wire stpcfg_pkg::stpcfg_rate_t  net_rate,
    input  wire logic                      net_enable,
    // Status
    output logic                           link_up
);
    logic nxt_link;

    // Master stays at 0 alone and only talks at its own rate
    // One slave is attached, so addresses stay distinct and no higher than fifteen
    always_comb begin
        nxt_link = net_enable && (slave_address != 4'h0)
                   && (net_rate == master_rate);
    end

    // Register the link flag
    always_ff @(posedge clk_sys) begin
        link_up <= reset ? 1'b0 : nxt_link;
    end
endmodule
`default_nettype wire

// >>> tb/stpcfg_top_asserts.sv
// Purpose: Port checks of the switch capture and current timer
// Assumes: Switches are steady around the capture edge
// Notes:   Idle counter saturates so long holds never wrap
`timescale 1ns/10ps
`default_nettype none

module stpcfg_top_asserts #(
    parameter int unsigned HOLD_CYCLES      = 20,
    parameter int unsigned HOLD_FAST_CYCLES = 8
) (
    // Clock and reset
    input wire logic                      clk_sys,
    input wire logic                      reset,
    // Inputs
    input wire logic [3:0]                address_switch,
    input wire logic [3:0]                rate_switch,
    input wire logic                      hold_time_select,
    input wire logic                      step_code_high,
    input wire logic                      step_code_mid,
    input wire logic                      drive_pulse,
    // Outputs
    input wire logic [3:0]                slave_address,
    input wire stpcfg_pkg::stpcfg_rate_t  net_rate,
    input wire logic                      net_enable,
    input wire logic                      config_valid,
    input wire logic                      addr_error,
    input wire logic                      rate_error,
    input wire stpcfg_pkg::stpcfg_div_t   step_division,
    input wire logic                      drive_current
);
    logic [31:0] idle_ff;
    logic [31:0] nxt_idle;
    logic [31:0] lim;
    logic        hs_ff;
    logic        nxt_hs;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    // Idle cycles since the last accepted pulse; interval select frozen at capture
    always_comb begin
        nxt_hs = config_valid ? hs_ff : hold_time_select;
        nxt_idle = (idle_ff == 32'hFFFF_FFFF) ? idle_ff : idle_ff + 32'h1;
        if (reset)
            nxt_idle = 32'hFFFF_FFFF;
        else if (drive_pulse && config_valid)
            nxt_idle = 32'h0;
    end

    // Register helper state
    always_ff @(posedge clk_sys) begin
        idle_ff <= nxt_idle;
        hs_ff <= nxt_hs;
    end
    assign lim = hs_ff ? HOLD_FAST_CYCLES : HOLD_CYCLES;

    a_addr_capture: assert property ($rose(config_valid) |->
        slave_address == $past(address_switch)) else $error("address not captured");
    a_addr_zero_off: assert property (config_valid && slave_address == 4'h0 |->
        !net_enable && addr_error) else $error("address zero on network");
    a_cfg_frozen: assert property (config_valid && $past(config_valid) |->
        $stable(slave_address) && $stable(net_rate) && $stable(step_division))
        else $error("configuration moved");
    a_rate_decode: assert property ($rose(config_valid) |-> net_rate ==
        ($past(rate_switch) == 4'h2 ? stpcfg_pkg::STPCFG_RATE_10M :
         $past(rate_switch) == 4'h3 ? stpcfg_pkg::STPCFG_RATE_20M :
         stpcfg_pkg::STPCFG_RATE_NONE)) else $error("rate decode wrong");
    a_rate_bad_off: assert property (config_valid && net_rate ==
        stpcfg_pkg::STPCFG_RATE_NONE |-> !net_enable && rate_error) else $error("bad rate on");
    a_div_finest: assert property ($rose(config_valid) && !$past(step_code_high) &&
        !$past(step_code_mid) |-> step_division == stpcfg_pkg::STPCFG_DIV_40)
        else $error("finest division missed");
    a_drive_on: assert property (config_valid && drive_pulse |=> drive_current)
        else $error("no drive level after pulse");
    a_drive_held: assert property (idle_ff < lim |-> drive_current)
        else $error("drive dropped early");
    a_hold_back: assert property (idle_ff >= lim |-> !drive_current)
        else $error("hold level late");

    c_online: cover property ($rose(config_valid) && net_enable);
    c_rate_bad: cover property (config_valid && rate_error);
    c_hold_back: cover property ($fell(drive_current));
endmodule

bind stpcfg_top stpcfg_top_asserts #(
    .HOLD_CYCLES      (HOLD_CYCLES),
    .HOLD_FAST_CYCLES (HOLD_FAST_CYCLES)
) u_chk (.*);
`default_nettype wire

// >>> tb/stpcfg_top_bench.sv
// Purpose: Self-checking bench for switch capture and current timer
// Assumes: Short hold intervals through parameters
// Notes:   Every row is a fresh power-on with its own switch set
`timescale 1ns/10ps
`default_nettype none

module stpcfg_top_bench;
    localparam int unsigned SLOW = 20;
    localparam int unsigned FAST = 8;
    localparam stpcfg_pkg::stpcfg_rate_t MRATE = stpcfg_pkg::STPCFG_RATE_20M;
    typedef struct packed {
        logic [3:0]               a;
        logic [3:0]               r;
        logic [2:0]               s;
        stpcfg_pkg::stpcfg_rate_t er;
        stpcfg_pkg::stpcfg_div_t  ed;
        logic                     ee;
    } stpcfg_row_t;

    logic                     clk_sys = 1'b0;
    logic                     reset = 1'b1;
    logic [3:0]               address_switch = 4'h0;
    logic [3:0]               rate_switch = 4'h0;
    logic                     hold_time_select = 1'b0;
    logic                     step_code_high = 1'b0;
    logic                     step_code_mid = 1'b0;
    logic                     step_code_low = 1'b0;
    logic                     pulse_input_type_select = 1'b0;
    logic                     drive_pulse = 1'b0;
    logic [3:0]               slave_address;
    stpcfg_pkg::stpcfg_rate_t net_rate;
    stpcfg_pkg::stpcfg_div_t  step_division;
    logic                     net_enable, config_valid, addr_error, rate_error;
    logic                     pulse_type_error, drive_current, link_up;
    int                       errors = 0;
    int                       check_count = 0;
    stpcfg_row_t              rows [8] = '{
        '{4'h1, 4'h2, 3'h7, stpcfg_pkg::STPCFG_RATE_10M, stpcfg_pkg::STPCFG_DIV_1, 1'b1},
        '{4'hF, 4'h3, 3'h6, stpcfg_pkg::STPCFG_RATE_20M, stpcfg_pkg::STPCFG_DIV_2, 1'b1},
        '{4'h5, 4'h0, 3'h5, stpcfg_pkg::STPCFG_RATE_NONE, stpcfg_pkg::STPCFG_DIV_4, 1'b0},
        '{4'hA, 4'h1, 3'h4, stpcfg_pkg::STPCFG_RATE_NONE, stpcfg_pkg::STPCFG_DIV_10, 1'b0},
        '{4'h0, 4'h3, 3'h3, stpcfg_pkg::STPCFG_RATE_20M, stpcfg_pkg::STPCFG_DIV_20, 1'b0},
        '{4'h3, 4'h6, 3'h2, stpcfg_pkg::STPCFG_RATE_NONE, stpcfg_pkg::STPCFG_DIV_40, 1'b0},
        '{4'h7, 4'hA, 3'h1, stpcfg_pkg::STPCFG_RATE_NONE, stpcfg_pkg::STPCFG_DIV_40, 1'b0},
        '{4'hC, 4'h3, 3'h0, stpcfg_pkg::STPCFG_RATE_20M, stpcfg_pkg::STPCFG_DIV_40, 1'b1}};

    // 50 MHz clock
    always #10 clk_sys = ~clk_sys;

    stpcfg_top #(.HOLD_CYCLES(SLOW), .HOLD_FAST_CYCLES(FAST)) dut (.*);
    stpcfg_master_model master (.*, .master_rate(MRATE));

    task automatic give_verdict;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    // Power-on with a switch set; pulses during reset must be dropped
    task automatic do_reset(input logic [3:0] a, input logic [3:0] r, input logic [2:0] s,
                            input logic hs, input logic p);
        @(posedge clk_sys);
        reset <= 1'b1;
        address_switch <= a;
        rate_switch <= r;
        {step_code_high, step_code_mid, step_code_low} <= s;
        hold_time_select <= hs;
        pulse_input_type_select <= (s == 3'h5);
        drive_pulse <= p;
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        drive_pulse <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask

    // Burst of back-to-back pulses, then idle exactly to the interval edge
    task automatic hold(input int unsigned n);
        @(posedge clk_sys);
        drive_pulse <= 1'b1;
        repeat (3) @(posedge clk_sys);
        drive_pulse <= 1'b0;
        #1;
        chk("drive_on", 1, drive_current);
        repeat (n - 1) @(posedge clk_sys);
        #1;
        chk("drive_held", 1, drive_current);
        @(posedge clk_sys);
        #1;
        chk("hold_back", 0, drive_current);
    endtask

    initial begin
        for (int i = 0; i < 8; i++) begin
            do_reset(rows[i].a, rows[i].r, rows[i].s, 1'b0, 1'b0);
            chk("slave_address", rows[i].a, slave_address);
            chk("net_rate", rows[i].er, net_rate);
            chk("net_enable", rows[i].ee, net_enable);
            chk("addr_error", rows[i].a == 4'h0, addr_error);
            chk("rate_error", rows[i].er == stpcfg_pkg::STPCFG_RATE_NONE, rate_error);
            chk("step_division", rows[i].ed, step_division);
            chk("pulse_type_error", rows[i].s == 3'h5, pulse_type_error);
            chk("config_valid", 1, config_valid);
            chk("link_up", rows[i].ee && rows[i].er == MRATE, link_up);
        end
        // Pulses in reset ignored, then the default interval
        do_reset(4'h9, 4'h3, 3'h3, 1'b0, 1'b1);
        chk("drive_in_reset", 0, drive_current);
        hold(SLOW);
        // Switch moves after capture change nothing, interval select included
        @(posedge clk_sys);
        address_switch <= 4'h2;
        rate_switch <= 4'h2;
        step_code_high <= 1'b1;
        hold_time_select <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        chk("frozen_address", 4'h9, slave_address);
        chk("frozen_rate", stpcfg_pkg::STPCFG_RATE_20M, net_rate);
        chk("frozen_division", stpcfg_pkg::STPCFG_DIV_20, step_division);
        hold(SLOW);
        // Reset in mid-run takes the unit offline again; pulses then are dropped
        @(posedge clk_sys);
        reset <= 1'b1;
        drive_pulse <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        chk("reset_valid", 0, config_valid);
        chk("reset_enable", 0, net_enable);
        chk("reset_address", 0, slave_address);
        chk("reset_drive", 0, drive_current);
        // Fast interval selected at power-on
        do_reset(4'h9, 4'h3, 3'h3, 1'b1, 1'b0);
        hold(FAST);
        give_verdict();
    end

    // Watchdog well beyond the 157 cycles the tests need
    initial begin
        repeat (4000) @(posedge clk_sys);
        errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
